// ---- rtl/pms_top.sv ----
// mac-side pipe sideband: block framing, training state, rate and swing control
// Notes on behaviour
// - at the third rate the transmit sync header per lane is 01 for ordered sets, 10 for data.
// - the transmit valid flag per lane is 0 to make the phy ignore that cycle, 1 for valid data.
// - receive data is used only in cycles where the per-lane receive valid flag is 1.
// - the training state is a 5-bit code, 00000 to 01111 from detect through recovery to L0.
// - codes 10000 to 10101, 11001 and 11010 to 11110 name disable through equalization phase 3.
// - rate 00 is 2.5 Gbps, 01 is 5.0 Gbps and any code with the upper bit set is 8.0 Gbps.
// - a 3-bit transmit margin select is driven from the link control 2 setting.
// - transmit swing high asks for full swing, low for half swing.
// - the accelerated-initialization output is high while shortened initialization is on.
// - every per-lane signal exists identically for lanes 0 to 7.
// - at the third rate the first transmitted word of each block carries transmit block begin.
//
// The Avalon-MM register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module pms_top (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic pclk_in,
    input wire logic [15:0] rx_block_type,
    input wire logic [7:0] rx_block_begin,
    input wire logic [7:0] rx_word_valid,
    output logic [15:0] tx_block_type,
    output logic [7:0] tx_block_begin,
    output logic [7:0] tx_word_valid,
    output logic [4:0] link_training_state,
    output logic [1:0] rate,
    output logic [2:0] tx_margin,
    output logic tx_swing,
    output logic accel_init_active
);
    localparam int L = pms_pkg::LANES;

    // address match, shared by read and write decode
    function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
        hit = (a == off);
    endfunction : hit

    // only the documented training codes may be reported
    function automatic logic lt_legal(input logic [4:0] c);
        lt_legal = (c <= pms_pkg::LT_L0S)
            || ((c >= pms_pkg::LT_L2_WAKE) && (c <= pms_pkg::LT_EQ_PH3));
    endfunction : lt_legal

    // reset release
    logic rst_s1_q;
    logic rst_s2_q;
    wire rst_n = rst_s2_q;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    // pipe clock and receive pins cross into the core clock
    logic pclk_s1_q;
    logic pclk_s2_q;
    logic pclk_s3_q;
    logic [15:0] rxt_s1_q;
    logic [15:0] rxt_s2_q;
    logic [7:0] rxb_s1_q;
    logic [7:0] rxb_s2_q;
    logic [7:0] rxv_s1_q;
    logic [7:0] rxv_s2_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pclk_s1_q <= 1'b0;
            pclk_s2_q <= 1'b0;
            pclk_s3_q <= 1'b0;
            rxt_s1_q <= '0;
            rxt_s2_q <= '0;
            rxb_s1_q <= '0;
            rxb_s2_q <= '0;
            rxv_s1_q <= '0;
            rxv_s2_q <= '0;
        end else begin
            pclk_s1_q <= pclk_in;
            pclk_s2_q <= pclk_s1_q;
            pclk_s3_q <= pclk_s2_q;
            rxt_s1_q <= rx_block_type;
            rxt_s2_q <= rxt_s1_q;
            rxb_s1_q <= rx_block_begin;
            rxb_s2_q <= rxb_s1_q;
            rxv_s1_q <= rx_word_valid;
            rxv_s2_q <= rxv_s1_q;
        end
    end

    // the pipe clock is slow against the core clock, so its edge is found by sampling
    wire pclk_rise = pclk_s2_q && !pclk_s3_q;

    // control registers
    logic [1:0] rate_q;
    logic [2:0] margin_q;
    logic swing_q;
    logic accel_q;
    logic txen_q;
    logic [4:0] train_q;
    logic [15:0] rxcnt_q;
    logic [15:0] rx_type_q;

    wire wr_ctrl = write && byteenable[0] && hit(address, pms_pkg::OFF_CTRL);
    wire wr_train = write && byteenable[0] && hit(address, pms_pkg::OFF_TRAIN);
    wire wr_txword = write && byteenable[0] && hit(address, pms_pkg::OFF_TXWORD);
    wire wr_rxcnt = write && hit(address, pms_pkg::OFF_RXCNT);
    wire train_ok = lt_legal(writedata[4:0]);
    wire gen3 = rate_q[pms_pkg::RATE_G3_BIT];

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rate_q <= pms_pkg::RATE_RST;
            margin_q <= pms_pkg::MARGIN_RST;
            swing_q <= pms_pkg::SWING_RST;
            accel_q <= pms_pkg::ACCEL_RST;
            txen_q <= pms_pkg::TXEN_RST;
        end else if (wr_ctrl) begin
            rate_q <= writedata[pms_pkg::CTRL_RATE_LSB +: 2];
            margin_q <= writedata[pms_pkg::CTRL_MARGIN_LSB +: 3];
            swing_q <= writedata[pms_pkg::CTRL_SWING];
            accel_q <= writedata[pms_pkg::CTRL_ACCEL];
            txen_q <= writedata[pms_pkg::CTRL_TXEN];
        end
    end

    // an undefined training code is dropped so the report never shows a gap code
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            train_q <= pms_pkg::LT_DETECT_QUIET;
        end else if (wr_train && train_ok) begin
            train_q <= writedata[4:0];
        end
    end

    assign rate = rate_q;
    assign tx_margin = margin_q;
    assign tx_swing = swing_q;
    assign accel_init_active = accel_q;
    assign link_training_state = train_q;

    // transmit block words go through the fifo; a full fifo stalls the bus write
    pms_fifo_if #(.W(pms_pkg::TXW_W)) txf ();

    pms_fifo #(
        .W(pms_pkg::TXW_W),
        .D(pms_pkg::FIFO_DEPTH)
    ) u_txfifo (
        .clock(clock),
        .rst_b(rst_n),
        .f(txf.fifo)
    );

    assign txf.in_valid = wr_txword;
    assign txf.in_data = writedata[pms_pkg::TXW_W-1:0];

    // one fifo word leaves per pipe clock while enabled at the third rate
    wire tx_fire = pclk_rise && gen3 && txen_q && txf.out_valid;
    assign txf.out_ready = tx_fire;

    wire [1:0] word_type = txf.out_data[pms_pkg::TXW_TYPE_LSB +: 2];
    wire word_begin = txf.out_data[pms_pkg::TXW_BEGIN];

    logic [1:0] txt_q;
    logic txb_q;
    logic txv_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            txt_q <= pms_pkg::BLK_DATA;
            txb_q <= 1'b0;
            txv_q <= 1'b1;
        end else if (!gen3) begin
            // framing has no meaning at the lower rates; data always counts
            txb_q <= 1'b0;
            txv_q <= 1'b1;
        end else if (tx_fire) begin
            txt_q <= word_type;
            txb_q <= word_begin;
            txv_q <= 1'b1;
        end else if (pclk_rise) begin
            // underrun or transmit disabled: skip the cycle, type held and begin cleared
            txb_q <= 1'b0;
            txv_q <= 1'b0;
        end
    end

    // receive side: block type per lane is taken on the first valid word of a block
    genvar g;
    generate
        for (g = 0; g < L; g++) begin : g_lane
            assign tx_block_type[2*g +: 2] = txt_q;
            assign tx_block_begin[g] = txb_q;
            assign tx_word_valid[g] = txv_q;

            wire take = pclk_rise && gen3 && rxv_s2_q[g] && rxb_s2_q[g];

            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    rx_type_q[2*g +: 2] <= pms_pkg::BLK_DATA;
                end else if (take) begin
                    rx_type_q[2*g +: 2] <= rxt_s2_q[2*g +: 2];
                end
            end
        end
    endgenerate

    // lane 0 block count; a count on the clearing write restarts the count at 1
    wire rx0_take = pclk_rise && gen3 && rxv_s2_q[0] && rxb_s2_q[0];

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rxcnt_q <= '0;
        end else if (rx0_take) begin
            rxcnt_q <= wr_rxcnt ? 16'h0001 : rxcnt_q + 16'h0001;
        end else if (wr_rxcnt) begin
            rxcnt_q <= '0;
        end
    end

    // bus reads take one wait cycle so read data comes from a flop
    logic rd_ack_q;
    logic [31:0] rdata_q;
    wire rd_start = read && !rd_ack_q;

    wire [31:0] ctrl_rd = {24'h000000, txen_q, accel_q, swing_q, margin_q, rate_q};
    wire [31:0] stat_rd = {14'h0000, !txf.in_ready, !txf.out_valid, rx_type_q};
    wire [31:0] rd_mux =
        hit(address, pms_pkg::OFF_CTRL) ? ctrl_rd :
        hit(address, pms_pkg::OFF_TRAIN) ? {27'h0000000, train_q} :
        hit(address, pms_pkg::OFF_STATUS) ? stat_rd :
        hit(address, pms_pkg::OFF_RXCNT) ? {16'h0000, rxcnt_q} :
        32'h00000000;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_ack_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            rd_ack_q <= rd_start;
            if (rd_start) begin
                rdata_q <= rd_mux;
            end
        end
    end

    assign readdata = rdata_q;
    assign waitrequest = read ? !rd_ack_q : (wr_txword && !txf.in_ready);
endmodule : pms_top

// ---- rtl/pms_pkg.sv ----
// shared constants for the pipe mac sideband block
package pms_pkg;
    localparam int LANES = 8;
    localparam int AW = 5;
    localparam int DW = 32;
    // register byte offsets
    localparam logic [4:0] OFF_CTRL = 5'h00;
    localparam logic [4:0] OFF_TRAIN = 5'h04;
    localparam logic [4:0] OFF_TXWORD = 5'h08;
    localparam logic [4:0] OFF_STATUS = 5'h0C;
    localparam logic [4:0] OFF_RXCNT = 5'h10;
    // control fields
    localparam int CTRL_RATE_LSB = 0;
    localparam int CTRL_MARGIN_LSB = 2;
    localparam int CTRL_SWING = 5;
    localparam int CTRL_ACCEL = 6;
    localparam int CTRL_TXEN = 7;
    // tx word fields
    localparam int TXW_TYPE_LSB = 0;
    localparam int TXW_BEGIN = 2;
    localparam int TXW_W = 3;
    // status fields
    localparam int STAT_EMPTY = 16;
    localparam int STAT_FULL = 17;
    localparam int FIFO_DEPTH = 32;
    // reset values
    localparam logic [1:0] RATE_RST = 2'h0;
    localparam logic [2:0] MARGIN_RST = 3'h0;
    localparam logic SWING_RST = 1'b1;
    localparam logic ACCEL_RST = 1'b0;
    localparam logic TXEN_RST = 1'b0;
    // sync header codes
    localparam logic [1:0] BLK_OS = 2'h1;
    localparam logic [1:0] BLK_DATA = 2'h2;
    // rate codes, upper bit set means the third rate
    localparam logic [1:0] RATE_G1 = 2'h0;
    localparam logic [1:0] RATE_G2 = 2'h1;
    localparam int RATE_G3_BIT = 1;
    // training state codes
    localparam logic [4:0] LT_DETECT_QUIET = 5'h00;
    localparam logic [4:0] LT_L0 = 5'h0F;
    localparam logic [4:0] LT_DISABLE = 5'h10;
    localparam logic [4:0] LT_L0S = 5'h15;
    localparam logic [4:0] LT_L2_WAKE = 5'h19;
    localparam logic [4:0] LT_EQ_PH3 = 5'h1E;
endpackage : pms_pkg

// ---- rtl/pms_fifo_if.sv ----
// valid/ready carrier between the register side and the transmit fifo
`timescale 1ns/10ps
interface pms_fifo_if #(
    parameter int W = 3
);
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;
    modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
    modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface : pms_fifo_if

// ---- rtl/pms_fifo.sv ----
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/10ps
module pms_fifo #(
    parameter int W = 3,
    parameter int D = 32
) (
    input wire logic clock,
    input wire logic rst_b,
    pms_fifo_if.fifo f
);
    localparam int PW = $clog2(D);
    logic [W-1:0] mem_q [D];
    logic [PW-1:0] wp_q;
    logic [PW-1:0] rp_q;
    logic [PW:0] cnt_q;
    wire push = f.in_valid && f.in_ready;
    wire pop = f.out_valid && f.out_ready;

    assign f.in_ready = (cnt_q != (PW+1)'(D));
    assign f.out_valid = (cnt_q != '0);
    assign f.out_data = mem_q[rp_q];

    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[wp_q] <= f.in_data;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == PW'(D-1)) ? '0 : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == PW'(D-1)) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule : pms_fifo

// ---- test/pms_top_monitor.sv ----
// port-level assertions for the pipe sideband block
`timescale 1ns/10ps
module pms_top_monitor (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic pclk_in,
    input wire logic [15:0] tx_block_type,
    input wire logic [7:0] tx_block_begin,
    input wire logic [7:0] tx_word_valid,
    input wire logic [4:0] link_training_state,
    input wire logic [1:0] rate,
    input wire logic [2:0] tx_margin,
    input wire logic tx_swing,
    input wire logic accel_init_active
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    logic [31:0] wd_q;
    wire logic wr_ok = write && !waitrequest && byteenable[0];
    wire logic ctrl_wr = wr_ok && address == pms_pkg::OFF_CTRL;
    wire logic tr_wr = wr_ok && address == pms_pkg::OFF_TRAIN;
    wire logic bad_code = writedata[4:0] inside {5'h16, 5'h17, 5'h18, 5'h1F};
    always_ff @(posedge clock) wd_q <= writedata;
    lanes_equal_a: assert property (tx_block_type == {8{tx_block_type[1:0]}}
        && tx_block_begin inside {8'h00, 8'hFF} && tx_word_valid inside {8'h00, 8'hFF})
        else $error("lanes differ");
    type_legal_a: assert property (tx_block_type[1:0] inside {2'h1, 2'h2})
        else $error("illegal block type");
    begin_valid_a: assert property (tx_block_begin[0] |-> tx_word_valid[0])
        else $error("block begin on a skipped word");
    low_rate_a: assert property ($fell(tx_word_valid[0]) || $rose(tx_block_begin[0]) |-> rate[1])
        else $error("skip or begin below third rate");
    tx_hold_a: assert property ((!rate[1])[*2] |-> $stable(tx_block_type))
        else $error("block type moved at low rate");
    tx_on_pclk_a: assert property (rate[1] && $past(rate) > 2'h1 &&
        ($changed(tx_word_valid) || $changed(tx_block_begin)) |-> $past(pclk_in) && $past(pclk_in, 2))
        else $error("tx change off pipe clock");
    ctrl_out_a: assert property (ctrl_wr |=>
        {accel_init_active, tx_swing, tx_margin, rate} == wd_q[6:0]) else $error("ctrl outputs");
    train_code_a: assert property (tr_wr && !bad_code |=> link_training_state == wd_q[4:0])
        else $error("training code not taken");
    bad_code_a: assert property (tr_wr && bad_code |=> $stable(link_training_state))
        else $error("undefined code taken");
    read_wait_a: assert property (read && !$past(read) |-> waitrequest ##1 !waitrequest)
        else $error("read wait cycle");
    unmapped_read_a: assert property (read && !waitrequest && address > 5'h10 |-> readdata == 32'h0)
        else $error("unmapped read not zero");
endmodule : pms_top_monitor
bind pms_top pms_top_monitor u_pms_top_monitor (.clock, .rst_b, .address, .read, .write,
    .writedata, .byteenable, .readdata, .waitrequest, .pclk_in, .tx_block_type, .tx_block_begin,
    .tx_word_valid, .link_training_state, .rate, .tx_margin, .tx_swing, .accel_init_active);

// ---- test/pms_phy_model.sv ----
// behavioural phy coding sublayer: pipe clock and receive sideband
`timescale 1ns/10ps
module pms_phy_model (
    output logic pclk_in,
    output logic [15:0] rx_block_type,
    output logic [7:0] rx_block_begin,
    output logic [7:0] rx_word_valid,
    input wire logic [15:0] nxt_type,
    input wire logic [7:0] nxt_begin,
    input wire logic [7:0] nxt_valid
);
    // phase offset keeps pipe clock edges off the core clock edges
    initial begin
        pclk_in = 1'b0;
        rx_block_type = 16'hAAAA;
        rx_block_begin = 8'h00;
        rx_word_valid = 8'h00;
        #37;
        forever #100 pclk_in = ~pclk_in;
    end
    // launched on the fall so the inputs are settled around the capturing rise
    always @(negedge pclk_in) begin
        rx_word_valid <= nxt_valid;
        rx_block_begin <= nxt_begin;
        for (int l = 0; l < 8; l++) begin
            // an ignored lane shows no stale header
            rx_block_type[2*l+:2] <= nxt_valid[l] ? nxt_type[2*l+:2] : ~rx_block_type[2*l+:2];
        end
    end
endmodule : pms_phy_model

// ---- test/test_pms_top.sv ----
// self-checking bench for the pipe sideband block
`timescale 1ns/10ps
module test_pms_top;
    logic clock, rst_b, read, write, waitrequest, tx_swing, accel_init_active, pclk_in;
    logic [4:0] address, link_training_state, train;
    logic [31:0] writedata, readdata, r, d, seed;
    logic [3:0] byteenable;
    logic [15:0] rx_block_type, tx_block_type, nxt_type, nt, rxst;
    logic [7:0] rx_block_begin, rx_word_valid, tx_block_begin, tx_word_valid, nxt_begin, nxt_valid;
    logic [7:0] ctrl;
    logic [1:0] rate;
    logic [2:0] tx_margin;
    logic [2:0] txq[$];
    int num_errors, cmp_count, cyc, rxcnt, n;
    pms_top u_pms_top (.clock, .rst_b, .address, .read, .write, .writedata, .byteenable,
        .readdata, .waitrequest, .pclk_in, .rx_block_type, .rx_block_begin, .rx_word_valid,
        .tx_block_type, .tx_block_begin, .tx_word_valid, .link_training_state, .rate,
        .tx_margin, .tx_swing, .accel_init_active);
    pms_phy_model u_pms_phy_model (.pclk_in, .rx_block_type, .rx_block_begin, .rx_word_valid,
        .nxt_type, .nxt_begin, .nxt_valid);
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_of_test();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test
    // one avalon access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] v,
        input logic [3:0] be);
        address <= a;
        writedata <= v;
        byteenable <= be;
        read <= !wr;
        write <= wr;
        do @(posedge clock); while (waitrequest !== 1'b0);
        r = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clock);
    endtask : bus
    task automatic outs();
        chk({accel_init_active, tx_swing, tx_margin, rate, link_training_state},
            {ctrl[6:0], train});
    endtask : outs
    task automatic push(input logic [2:0] w);
        bus(1'b1, pms_pkg::OFF_TXWORD, {29'h0, w}, 4'h1);
        txq.push_back(w);
    endtask : push
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            end_of_test();
        end
    end
    // expected transmit sideband after every pipe clock rise
    initial begin
        logic [2:0] w;
        logic [1:0] lt;
        logic [7:0] ev;
        logic g3;
        lt = pms_pkg::BLK_DATA;
        @(posedge rst_b);
        forever begin
            @(posedge pclk_in);
            w = {1'b0, lt};
            g3 = ctrl[pms_pkg::CTRL_RATE_LSB + pms_pkg::RATE_G3_BIT];
            // at the third rate an empty or disabled link skips the cycle
            ev = g3 ? 8'h00 : 8'hFF;
            if (g3 && ctrl[pms_pkg::CTRL_TXEN] && txq.size() != 0) begin
                w = txq.pop_front();
                lt = w[1:0];
                ev = 8'hFF;
            end
            repeat (6) @(posedge clock);
            chk({tx_block_type, tx_block_begin, tx_word_valid}, {{8{lt}}, {8{w[2]}}, ev});
        end
    end
    initial begin
        {rst_b, read, write, address, writedata, byteenable, nxt_begin, nxt_valid} = '0;
        {seed, nxt_type, rxst, ctrl, train} = {32'h0000002B, 16'hAAAA, 16'hAAAA, 8'h20, 5'h00};
        rxcnt = 0;
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        repeat (3) @(posedge clock);
        outs();
        bus(1'b0, pms_pkg::OFF_STATUS, 0, 4'hF);
        chk(r, {14'h0, 2'b01, rxst});
        for (int i = 0; i < 10; i++) begin
            // rate changes land in the low pipe clock phase, well clear of the next rise
            @(negedge pclk_in);
            @(posedge clock);
            d = (rnd() & 32'hFFFF_FF7C) | 32'(i % 4);
            bus(1'b1, pms_pkg::OFF_CTRL, d, d[11:8]);
            if (d[8]) ctrl = d[7:0];
            bus(1'b0, pms_pkg::OFF_CTRL, 0, 4'hF);
            chk(r, {24'h0, ctrl});
            outs();
        end
        for (int i = 0; i < 32; i++) begin
            bus(1'b1, pms_pkg::OFF_TRAIN, 32'(i), 4'h1);
            if (!(i inside {22, 23, 24, 31})) train = 5'(i);
            bus(1'b0, pms_pkg::OFF_TRAIN, 0, 4'hF);
            chk(r, {27'h0, train});
            outs();
        end
        bus(1'b1, 5'h14, 32'hFFFF_FFFF, 4'hF);
        bus(1'b0, 5'h14, 0, 4'hF);
        chk(r, 32'h0);
        outs();
        // fill with the link idle, then the 33rd word must wait for a drain
        for (int i = 0; i < 32; i++) begin
            d = rnd();
            push({d[2], d[0] ? pms_pkg::BLK_OS : pms_pkg::BLK_DATA});
        end
        bus(1'b0, pms_pkg::OFF_STATUS, 0, 4'hF);
        chk(r, {14'h0, 2'b10, rxst});
        @(negedge pclk_in);
        @(posedge clock);
        bus(1'b1, pms_pkg::OFF_CTRL, 32'hA2, 4'h1);
        ctrl = 8'hA2;
        push(3'h5);
        n = 0;
        while (txq.size() != 0 && n < 2000) begin
            @(posedge clock);
            n++;
        end
        // a drain that never finishes counts as a mismatch
        if (n == 2000) begin
            num_errors++;
        end
        repeat (16) @(posedge clock);
        for (int i = 0; i < 13; i++) begin
            @(posedge pclk_in);
            @(posedge clock);
            d = rnd();
            for (int l = 0; l < 8; l++) begin
                nt[2*l+:2] = d[l] ? pms_pkg::BLK_DATA : pms_pkg::BLK_OS;
                if (d[l+8] && d[l+16] && i < 12) rxst[2*l+:2] = nt[2*l+:2];
                if (l == 0 && d[8] && d[16] && i < 12) rxcnt++;
            end
            nxt_type <= nt;
            nxt_begin <= d[15:8];
            nxt_valid <= (i < 12) ? d[23:16] : 8'h00;
        end
        repeat (2) @(posedge pclk_in);
        repeat (6) @(posedge clock);
        bus(1'b0, pms_pkg::OFF_STATUS, 0, 4'hF);
        chk(r, {14'h0, 2'b01, rxst});
        bus(1'b0, pms_pkg::OFF_RXCNT, 0, 4'hF);
        chk(r, 32'(rxcnt));
        bus(1'b1, pms_pkg::OFF_RXCNT, 0, 4'h0);
        bus(1'b0, pms_pkg::OFF_RXCNT, 0, 4'hF);
        chk(r, 32'h0);
        outs();
        end_of_test();
    end
endmodule : test_pms_top
